// ### hdl/radio_mode_sequencer.sv
`timescale 1ns/100ps
module radio_mode_sequencer #(
    parameter int DEPTH = 64,
    parameter int LISTEN_CYCLES = mode_seq_pkg::LISTEN_CYCLES,
    parameter int CYCLE_BASE = mode_seq_pkg::CYCLE_BASE_CYCLES
) (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic HOST_VALID,
    input wire logic [7:0] HOST_DATA,
    input wire logic CMD_SEQ,
    input wire logic SLEEP_PIN,
    input wire logic RF_DETECT,
    input wire logic RF_ERROR,
    input wire logic RF_VALID,
    input wire logic [7:0] RF_DATA,
    input wire logic RF_END,
    input wire logic [15:0] RF_NET_ID,
    input wire logic [7:0] RF_CHAN,
    input wire logic [7:0] RF_DEST,
    input wire logic TX_READY,
    output logic TX_VALID,
    output logic [7:0] TX_DATA,
    output logic TX_INIT,
    output logic TX_LAST,
    output logic OUT_VALID,
    output logic [7:0] OUT_DATA,
    output logic OUT_COMMIT,
    output logic OUT_DROP,
    output logic CTS_B,
    output logic PWR,
    output logic [2:0] MODE
);
    localparam int AW = $clog2(DEPTH);

    // Next CRC after one byte, used on the transmit path only
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            if (r[15] ^ d[i]) begin
                r = {r[14:0], 1'b0} ^ mode_seq_pkg::CRC_POLY;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction : crc_step

    mode_seq_pkg::mode_t state_reg, state_next;
    logic [3:0] sm_reg;
    logic pw_reg;
    logic [15:0] init_len_reg;
    logic [31:0] idle_time_reg;
    logic [15:0] net_id_reg;
    logic [7:0] chan_reg;
    logic [7:0] my_addr_reg;
    logic [7:0] dest_reg;
    logic [7:0] fifo_mem [DEPTH];
    logic [AW:0] wptr_reg, rptr_reg;
    logic [31:0] cnt_reg;
    logic [31:0] idle_cnt_reg;
    logic [31:0] listen_cnt_reg;
    logic [6:0] pkt_cnt_reg;
    logic [15:0] crc_reg;
    logic crc_hi_reg;
    logic listening_reg;
    logic first_tx_done_reg;
    logic [15:0] rx_good_reg, rx_drop_reg;
    logic rx_hdr_ok_reg;

    // Two-stage synchronisers for pin inputs
    logic sleep_s1, sleep_s2, detect_s1, detect_s2;
    always_ff @(posedge CLOCK) begin
        sleep_s1 <= SLEEP_PIN;
        sleep_s2 <= sleep_s1;
        detect_s1 <= RF_DETECT;
        detect_s2 <= detect_s1;
    end

    // Buffer status and decodes
    wire fifo_empty = (wptr_reg == rptr_reg);
    wire fifo_full = (wptr_reg[AW] != rptr_reg[AW]) &&
                     (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
    wire push = HOST_VALID && !fifo_full && !CTS_B;
    wire tx_fire = TX_VALID && TX_READY;
    wire pin_mode = (sm_reg == 4'h1);
    wire cyc_mode = (sm_reg >= 4'h3) && (sm_reg <= 4'h8);
    wire pin_sleep_req = pin_mode && sleep_s2;
    wire idle_expired = (idle_cnt_reg >= idle_time_reg);
    wire listen_done = (listen_cnt_reg >= 32'(LISTEN_CYCLES));
    wire [31:0] cyc_len = 32'(CYCLE_BASE) << (sm_reg - 4'h3);
    wire hdr_ok = (RF_NET_ID == net_id_reg) && (RF_CHAN == chan_reg) &&
                  (RF_DEST == my_addr_reg);
    wire [7:0] fifo_head = fifo_mem[rptr_reg[AW-1:0]];
    // Registered beats must show the head and CRC after this edge
    wire data_fire = state_reg == mode_seq_pkg::ST_TX_DATA && tx_fire;
    wire [7:0] head_next = fifo_mem[AW'(rptr_reg + data_fire)];
    wire [15:0] crc_next = data_fire ? crc_step(crc_reg, fifo_head)
                                     : crc_reg;
    wire hi_next = crc_hi_reg ^
                   (state_reg == mode_seq_pkg::ST_TX_CRC && tx_fire);
    wire pkt_end = (pkt_cnt_reg == mode_seq_pkg::MAX_PACKET - 7'h1) ||
                   (rptr_reg + 1'b1 == wptr_reg);
    wire do_wr_ctrl = WR && ADDR == mode_seq_pkg::ADDR_CTRL;
    wire cmd_exit = do_wr_ctrl && WDATA[mode_seq_pkg::CMD_EXIT_BIT];

    // Mode transitions
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            mode_seq_pkg::ST_IDLE: begin
                if (CMD_SEQ) begin
                    state_next = mode_seq_pkg::ST_CMD;
                end else if (detect_s2) begin
                    state_next = mode_seq_pkg::ST_RX;
                end else if (!fifo_empty && !listening_reg) begin
                    state_next = mode_seq_pkg::ST_TX_INIT;
                end else if (pin_sleep_req) begin
                    state_next = mode_seq_pkg::ST_SLEEP;
                end else if (cyc_mode && ((idle_expired && !listening_reg) ||
                             (listening_reg && listen_done))) begin
                    state_next = mode_seq_pkg::ST_SLEEP;
                end
            end
            mode_seq_pkg::ST_TX_INIT: begin
                if (tx_fire && cnt_reg == 32'(init_len_reg) - 32'h1) begin
                    state_next = mode_seq_pkg::ST_TX_DATA;
                end
            end
            mode_seq_pkg::ST_TX_DATA: begin
                if (tx_fire && pkt_end) begin
                    state_next = mode_seq_pkg::ST_TX_CRC;
                end
            end
            mode_seq_pkg::ST_TX_CRC: begin
                if (tx_fire && crc_hi_reg) begin
                    // Further data continues without initializer
                    state_next = fifo_empty ? mode_seq_pkg::ST_IDLE
                                            : mode_seq_pkg::ST_TX_DATA;
                end
            end
            mode_seq_pkg::ST_RX: begin
                if (!detect_s2 || RF_ERROR) begin
                    state_next = mode_seq_pkg::ST_IDLE;
                end
            end
            mode_seq_pkg::ST_SLEEP: begin
                // Always exits via idle
                if (pin_mode && !sleep_s2) begin
                    state_next = mode_seq_pkg::ST_IDLE;
                end else if (cyc_mode && (cnt_reg >= cyc_len ||
                             (pw_reg && !sleep_s2))) begin
                    state_next = mode_seq_pkg::ST_IDLE;
                end else if (!pin_mode && !cyc_mode) begin
                    state_next = mode_seq_pkg::ST_IDLE;
                end
            end
            mode_seq_pkg::ST_CMD: begin
                if (cmd_exit) begin
                    state_next = mode_seq_pkg::ST_IDLE;
                end
            end
            default: state_next = mode_seq_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            state_reg <= mode_seq_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Input buffer write side
    always_ff @(posedge CLOCK) begin
        if (push) begin
            fifo_mem[wptr_reg[AW-1:0]] <= HOST_DATA;
        end
    end

    // Pointers; read advances as data bytes leave
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
        end else begin
            if (push) begin
                wptr_reg <= wptr_reg + 1'b1;
            end
            if (data_fire) begin
                rptr_reg <= rptr_reg + 1'b1;
            end
        end
    end

    // General counter: initializer bytes or sleep interval
    always_ff @(posedge CLOCK) begin
        if (!RST_B || state_next != state_reg) begin
            cnt_reg <= '0;
        end else if (state_reg == mode_seq_pkg::ST_SLEEP ||
                     (state_reg == mode_seq_pkg::ST_TX_INIT && tx_fire)) begin
            cnt_reg <= cnt_reg + 32'h1;
        end
    end

    // Inactivity timer restarts whenever the mode is not idle, and holds once expired
    always_ff @(posedge CLOCK) begin
        if (!RST_B || state_reg != mode_seq_pkg::ST_IDLE) begin
            idle_cnt_reg <= '0;
        end else if (!idle_expired) begin
            idle_cnt_reg <= idle_cnt_reg + 32'h1;
        end
    end

    // Listen window after a cyclic wake
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            listening_reg <= 1'b0;
            listen_cnt_reg <= '0;
        end else if (state_reg == mode_seq_pkg::ST_SLEEP &&
                     state_next == mode_seq_pkg::ST_IDLE) begin
            // Pin wake is a full wake, not a listen slot
            listening_reg <= cyc_mode && !(pw_reg && !sleep_s2);
            listen_cnt_reg <= '0;
        end else if (state_reg != mode_seq_pkg::ST_IDLE) begin
            listening_reg <= 1'b0;
        end else if (listening_reg && !listen_done) begin
            listen_cnt_reg <= listen_cnt_reg + 32'h1;
        end
    end

    // Packet byte count, CRC and first-transmission marker
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            pkt_cnt_reg <= '0;
            crc_reg <= mode_seq_pkg::CRC_SEED;
            crc_hi_reg <= 1'b0;
            first_tx_done_reg <= 1'b0;
        end else if (state_reg == mode_seq_pkg::ST_TX_INIT) begin
            pkt_cnt_reg <= '0;
            crc_reg <= mode_seq_pkg::CRC_SEED;
            crc_hi_reg <= 1'b0;
            first_tx_done_reg <= 1'b1;
        end else if (data_fire) begin
            pkt_cnt_reg <= pkt_cnt_reg + 7'h1;
            crc_reg <= crc_next;
        end else if (state_reg == mode_seq_pkg::ST_TX_CRC && tx_fire) begin
            crc_hi_reg <= !crc_hi_reg;
            if (crc_hi_reg) begin
                pkt_cnt_reg <= '0;
                crc_reg <= mode_seq_pkg::CRC_SEED;
            end
        end
    end

    // Byte stream to the modem, registered
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            TX_VALID <= 1'b0;
            TX_DATA <= '0;
            TX_INIT <= 1'b0;
            TX_LAST <= 1'b0;
        end else begin
            TX_VALID <= state_next == mode_seq_pkg::ST_TX_INIT ||
                        state_next == mode_seq_pkg::ST_TX_DATA ||
                        state_next == mode_seq_pkg::ST_TX_CRC;
            TX_INIT <= state_next == mode_seq_pkg::ST_TX_INIT;
            TX_LAST <= state_next == mode_seq_pkg::ST_TX_CRC && hi_next;
            case (state_next)
                // Initializer carries hopping channel
                mode_seq_pkg::ST_TX_INIT: TX_DATA <= chan_reg;
                mode_seq_pkg::ST_TX_DATA: TX_DATA <= head_next;
                mode_seq_pkg::ST_TX_CRC: TX_DATA <= hi_next ?
                    crc_next[15:8] : crc_next[7:0];
                default: TX_DATA <= '0;
            endcase
        end
    end

    // Receive path: filter, check RF_ERROR, forward to output buffer
    always_ff @(posedge CLOCK) begin
        if (!RST_B || state_reg != mode_seq_pkg::ST_RX) begin
            OUT_VALID <= 1'b0;
            OUT_DATA <= '0;
            OUT_COMMIT <= 1'b0;
            OUT_DROP <= 1'b0;
            rx_hdr_ok_reg <= 1'b1;
            if (!RST_B) begin
                rx_good_reg <= '0;
                rx_drop_reg <= '0;
            end
        end else begin
            OUT_VALID <= RF_VALID && hdr_ok;
            OUT_DATA <= RF_DATA;
            OUT_COMMIT <= 1'b0;
            OUT_DROP <= 1'b0;
            if (RF_VALID && !hdr_ok) begin
                rx_hdr_ok_reg <= 1'b0;
            end
            if (RF_END) begin
                if (rx_hdr_ok_reg && hdr_ok && !RF_ERROR) begin
                    OUT_COMMIT <= 1'b1;
                    rx_good_reg <= rx_good_reg + 16'h1;
                end else begin
                    OUT_DROP <= 1'b1;
                    rx_drop_reg <= rx_drop_reg + 16'h1;
                end
                rx_hdr_ok_reg <= 1'b1;
            end
        end
    end

    // Pin outputs: CTS off and power low while asleep
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            CTS_B <= 1'b1;
            PWR <= 1'b0;
            MODE <= 3'h0;
        end else begin
            // One slot early, since the host sees CTS_B a cycle late
            CTS_B <= state_next == mode_seq_pkg::ST_SLEEP ||
                     (wptr_reg - rptr_reg) >= (AW+1)'(DEPTH - 1);
            PWR <= state_next != mode_seq_pkg::ST_SLEEP;
            MODE <= state_next;
        end
    end

    // Configuration registers
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            sm_reg <= mode_seq_pkg::SM_RST;
            pw_reg <= 1'b0;
            init_len_reg <= mode_seq_pkg::INIT_LEN_RST;
            idle_time_reg <= mode_seq_pkg::IDLE_TIME_RST;
            net_id_reg <= mode_seq_pkg::NET_ID_RST;
            chan_reg <= '0;
            my_addr_reg <= '0;
            dest_reg <= '0;
        end else if (WR) begin
            case (ADDR)
                mode_seq_pkg::ADDR_SLEEP: begin
                    sm_reg <= WDATA[3:0];
                    pw_reg <= WDATA[mode_seq_pkg::PW_BIT];
                end
                mode_seq_pkg::ADDR_INIT: begin
                    init_len_reg <= WDATA[15:0];
                    net_id_reg <= WDATA[31:16];
                end
                mode_seq_pkg::ADDR_ADDR: begin
                    chan_reg <= WDATA[7:0];
                    my_addr_reg <= WDATA[15:8];
                    dest_reg <= WDATA[23:16];
                end
                mode_seq_pkg::ADDR_COUNTS: idle_time_reg <= WDATA;
                default: ;
            endcase
        end
    end

    // Read mux, data valid one cycle after the strobe
    wire [31:0] rd_mux =
        ADDR == mode_seq_pkg::ADDR_SLEEP ? {27'h0, pw_reg, sm_reg} :
        ADDR == mode_seq_pkg::ADDR_INIT ? {net_id_reg, init_len_reg} :
        ADDR == mode_seq_pkg::ADDR_ADDR ?
            {8'h0, dest_reg, my_addr_reg, chan_reg} :
        ADDR == mode_seq_pkg::ADDR_COUNTS ? idle_time_reg :
        ADDR == mode_seq_pkg::ADDR_STATUS ?
            {fifo_empty, fifo_full, first_tx_done_reg, listening_reg,
             1'b0, 3'(state_reg), 8'h0, 8'(wptr_reg - rptr_reg), 8'h0} :
        ADDR == mode_seq_pkg::ADDR_CTRL ? {rx_drop_reg, rx_good_reg} :
        32'h0;
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            RDATA <= '0;
        end else begin
            RDATA <= RD ? rd_mux : 32'h0;
        end
    end
endmodule : radio_mode_sequencer

// ### include/mode_seq_pkg.sv
package mode_seq_pkg;
    // Operating modes
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_TX_INIT = 3'h1,
        ST_TX_DATA = 3'h2,
        ST_TX_CRC = 3'h3,
        ST_RX = 3'h4,
        ST_SLEEP = 3'h5,
        ST_CMD = 3'h6
    } mode_t;

    // Register addresses (address = register index * 4)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SLEEP = 8'h04;
    localparam logic [7:0] ADDR_INIT = 8'h08;
    localparam logic [7:0] ADDR_ADDR = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_COUNTS = 8'h14;

    // Field positions
    localparam int SM_LSB = 0;
    localparam int PW_BIT = 4;
    localparam int CMD_BIT = 0;
    localparam int CMD_EXIT_BIT = 1;

    // Reset values, CRC polynomial and packet length limit
    localparam logic [3:0] SM_RST = 4'h0;
    localparam logic [15:0] INIT_LEN_RST = 16'h0010;
    localparam logic [31:0] IDLE_TIME_RST = 32'h0000_1000;
    localparam logic [15:0] NET_ID_RST = 16'h3332;
    localparam logic [15:0] CRC_SEED = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [6:0] MAX_PACKET = 7'h40;

    // Cyclic sleep and listen timing
    localparam int CLOCK_MHZ = 250;
    localparam int LISTEN_MS = 100;
    localparam int LISTEN_CYCLES = LISTEN_MS * 1000 * CLOCK_MHZ;
    localparam int CYCLE_BASE_CYCLES = 4096;
endpackage : mode_seq_pkg

// ### testbench/radio_host_model.sv
`timescale 1ns/100ps
module radio_host_model (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic CTS_B,
    input wire logic sleep_req,
    output logic HOST_VALID,
    output logic [7:0] HOST_DATA,
    output logic SLEEP_PIN
);
    logic [7:0] pend_q[$];
    logic [7:0] last_reg = 8'h00;
    initial begin
        HOST_VALID = 1'b0;
        HOST_DATA = 8'hff;
        SLEEP_PIN = 1'b0;
    end
    task automatic put(input logic [7:0] b);
        pend_q.push_back(b);
    endtask : put
    // A byte leaves only at an edge that saw CTS_B low; idle line inverts
    always @(posedge CLOCK) begin
        if (RST_B && HOST_VALID && !CTS_B) begin
            last_reg = HOST_DATA;
            void'(pend_q.pop_front());
        end
        HOST_VALID <= RST_B && pend_q.size() > 0;
        HOST_DATA <= pend_q.size() > 0 ? pend_q[0] : ~last_reg;
        SLEEP_PIN <= sleep_req;
    end
endmodule : radio_host_model

// ### testbench/radio_mode_sequencer_checker.sv
`timescale 1ns/100ps
module radio_mode_sequencer_checker (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic RF_ERROR,
    input wire logic TX_READY,
    input wire logic TX_VALID,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_INIT,
    input wire logic TX_LAST,
    input wire logic OUT_COMMIT,
    input wire logic OUT_DROP,
    input wire logic CTS_B,
    input wire logic PWR,
    input wire logic [2:0] MODE
);
    localparam logic [2:0] IDL = mode_seq_pkg::ST_IDLE;
    localparam logic [2:0] INI = mode_seq_pkg::ST_TX_INIT;
    localparam logic [2:0] RCV = mode_seq_pkg::ST_RX;
    localparam logic [2:0] SLP = mode_seq_pkg::ST_SLEEP;
    logic [7:0] beat_reg;
    logic [7:0] beat_next;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    // Packet beats since last tail
    assign beat_next = (TX_VALID && TX_READY && TX_LAST) ? 8'h00 :
        (TX_VALID && TX_READY && !TX_INIT) ? beat_reg + 8'h01 : beat_reg;
    always_ff @(posedge CLOCK) begin
        beat_reg <= RST_B ? beat_next : 8'h00;
    end
    // Transmit stall and steps of a mode change
    sequence s_stall;
        TX_VALID && !TX_READY;
    endsequence
    sequence s_enter(logic [2:0] m);
        $changed(MODE) && MODE == m;
    endsequence
    sequence s_leave(logic [2:0] m);
        $past(MODE) == m && MODE != m;
    endsequence
    chk_tx_hold: assert property (
        s_stall |=> TX_VALID && $stable({TX_DATA, TX_INIT, TX_LAST}))
        else $error("tx beat changed while stalled");
    chk_packet_len: assert property (
        beat_reg <= 8'h41) else $error("packet longer than 64 bytes");
    chk_init_entry: assert property (
        s_enter(INI) |-> $past(MODE) == IDL)
        else $error("initializer not started from idle");
    chk_rx_entry: assert property (
        s_enter(RCV) |-> $past(MODE) == IDL)
        else $error("receive not entered from idle");
    chk_rx_exit: assert property (
        s_leave(RCV) |-> MODE == IDL) else $error("receive left to non-idle");
    chk_err_exit: assert property (
        MODE == RCV && RF_ERROR |-> ##[1:4] MODE == IDL)
        else $error("receive kept after error");
    chk_sleep_entry: assert property (
        s_enter(SLP) |-> $past(MODE) == IDL)
        else $error("sleep not entered from idle");
    chk_sleep_exit: assert property (
        s_leave(SLP) |-> MODE == IDL) else $error("sleep left to non-idle");
    chk_sleep_quiet: assert property (
        MODE == SLP |-> !TX_VALID) else $error("transmit while asleep");
    chk_sleep_pins: assert property (
        (MODE == SLP) [*2] |-> CTS_B && !PWR)
        else $error("sleep pins wrong");
    chk_verdict_one: assert property (
        !(OUT_COMMIT && OUT_DROP)) else $error("commit and drop together");
endmodule : radio_mode_sequencer_checker
bind radio_mode_sequencer radio_mode_sequencer_checker chk_i (
    .CLOCK(CLOCK), .RST_B(RST_B), .RF_ERROR(RF_ERROR),
    .TX_READY(TX_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
    .TX_INIT(TX_INIT), .TX_LAST(TX_LAST), .OUT_COMMIT(OUT_COMMIT),
    .OUT_DROP(OUT_DROP), .CTS_B(CTS_B), .PWR(PWR), .MODE(MODE));

// ### testbench/radio_mode_sequencer_tb_top.sv
`timescale 1ns/100ps
module radio_mode_sequencer_tb_top;
    localparam logic [7:0] CHAN = 8'h15;
    localparam logic [7:0] NODE = 8'h5a;
    localparam logic [15:0] NET = 16'h1234;
    localparam int INIT_N = 3;
    logic CLOCK = 1'b0;
    logic RST_B = 1'b0;
    logic [7:0] ADDR = 8'h00;
    logic [31:0] WDATA = 32'h0;
    logic WR = 1'b0, RD = 1'b0, CMD_SEQ = 1'b0, TX_READY = 1'b0;
    logic RF_DETECT = 1'b0, RF_ERROR = 1'b0, RF_VALID = 1'b0;
    logic RF_END = 1'b0, sleep_req = 1'b0, stall = 1'b0, rd_seen = 1'b0;
    logic [7:0] RF_DATA = 8'h00, RF_CHAN = 8'h00, RF_DEST = 8'h00;
    logic [15:0] RF_NET_ID = 16'h0;
    logic [31:0] RDATA, seed = 32'h2b0feb46;
    logic HOST_VALID, SLEEP_PIN, TX_VALID, TX_INIT, TX_LAST;
    logic OUT_VALID, OUT_COMMIT, OUT_DROP, CTS_B, PWR;
    logic [7:0] HOST_DATA, TX_DATA, OUT_DATA;
    logic [2:0] MODE;
    logic [9:0] tx_q[$];
    logic [7:0] pay_q[$], out_q[$];
    logic [1:0] ev_q[$];
    logic [31:0] rd_q[$];
    int err_total = 0, compares = 0, beats = 0, n;
    radio_host_model host (.CLOCK(CLOCK), .RST_B(RST_B), .CTS_B(CTS_B),
        .sleep_req(sleep_req), .HOST_VALID(HOST_VALID),
        .HOST_DATA(HOST_DATA), .SLEEP_PIN(SLEEP_PIN));
    radio_mode_sequencer #(.DEPTH(64), .LISTEN_CYCLES(50), .CYCLE_BASE(16))
    uut (.CLOCK(CLOCK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .HOST_VALID(HOST_VALID),
        .HOST_DATA(HOST_DATA), .CMD_SEQ(CMD_SEQ), .SLEEP_PIN(SLEEP_PIN),
        .RF_DETECT(RF_DETECT), .RF_ERROR(RF_ERROR), .RF_VALID(RF_VALID),
        .RF_DATA(RF_DATA), .RF_END(RF_END), .RF_NET_ID(RF_NET_ID),
        .RF_CHAN(RF_CHAN), .RF_DEST(RF_DEST), .TX_READY(TX_READY),
        .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_INIT(TX_INIT),
        .TX_LAST(TX_LAST), .OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA),
        .OUT_COMMIT(OUT_COMMIT), .OUT_DROP(OUT_DROP), .CTS_B(CTS_B),
        .PWR(PWR), .MODE(MODE));
    always #2 CLOCK = ~CLOCK;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                              input logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0);
        end
        return c;
    endfunction : crc_step
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic results;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results
    task automatic tick;
        @(posedge CLOCK);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLOCK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLOCK);
        WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        @(posedge CLOCK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLOCK);
        RD <= 1'b0;
    endtask : rd
    task automatic wait_mode(input logic [2:0] m, input int bound);
        n = 0;
        while (MODE !== m && n < bound) begin
            tick();
            n++;
        end
        chk("MODE", {29'h0, m}, {29'h0, MODE});
        if (MODE !== m) results();
    endtask : wait_mode
    task automatic wait_tx(input int left);
        n = 0;
        while (beats < left && n < 3000) begin
            tick();
            n++;
        end
        if (n == 3000) chk("TX_PROGRESS", 1, 0);
        if (n == 3000) results();
    endtask : wait_tx
    // Host bytes go to the host model and to the expected payload
    task automatic host_send(input int cnt);
        logic [31:0] s;
        s = seed;
        for (int i = 0; i < cnt; i++) begin
            s = xs(s ^ 32'(i));
            pay_q.push_back(s[7:0]);
            host.put(s[7:0]);
        end
    endtask : host_send
    task automatic exp_packet(input logic init, input int cnt);
        logic [15:0] c;
        c = mode_seq_pkg::CRC_SEED;
        for (int i = 0; i < INIT_N && init; i++) begin
            tx_q.push_back({2'b10, CHAN});
        end
        for (int i = 0; i < cnt; i++) begin
            c = crc_step(c, pay_q[0]);
            tx_q.push_back({2'b00, pay_q.pop_front()});
        end
        tx_q.push_back({2'b00, c[7:0]});
        tx_q.push_back({2'b01, c[15:8]});
    endtask : exp_packet
    task automatic rx_pkt(input logic [7:0] dest, input logic err);
        logic ok;
        ok = dest == NODE && !err;
        @(posedge CLOCK);
        RF_DEST <= dest;
        for (int i = 0; i < 4; i++) begin
            @(posedge CLOCK);
            RF_VALID <= 1'b1;
            RF_DATA <= seed[7:0] ^ 8'(i);
            if (ok) out_q.push_back(seed[7:0] ^ 8'(i));
            @(posedge CLOCK);
            RF_VALID <= 1'b0;
        end
        ev_q.push_back(ok ? 2'b10 : 2'b01);
        @(posedge CLOCK);
        RF_END <= 1'b1;
        RF_ERROR <= err;
        @(posedge CLOCK);
        RF_END <= 1'b0;
        RF_ERROR <= 1'b0;
    endtask : rx_pkt
    // Random modem stalls; results compared against the oldest note
    always @(posedge CLOCK) begin
        seed = xs(seed);
        TX_READY <= !stall && seed[9:8] != 2'b00;
        rd_seen <= RD;
        if (rd_seen) chk("RDATA", rd_q.pop_front(), RDATA);
        if (RST_B && TX_VALID && TX_READY) begin
            beats++;
            chk("TX", tx_q.size() ? {22'h0, tx_q.pop_front()} : 32'hffff,
                {22'h0, TX_INIT, TX_LAST, TX_DATA});
        end
        if (RST_B && OUT_VALID && out_q.size() > 0)
            chk("OUT_DATA", {24'h0, out_q.pop_front()}, {24'h0, OUT_DATA});
        if (RST_B && (OUT_COMMIT || OUT_DROP))
            chk("VERDICT", ev_q.size() ? {30'h0, ev_q.pop_front()} : 32'h3,
                {30'h0, OUT_COMMIT, OUT_DROP});
    end
    initial begin
        repeat (3) @(posedge CLOCK);
        RST_B <= 1'b1;
        RF_NET_ID <= NET;
        RF_CHAN <= CHAN;
        rd(mode_seq_pkg::ADDR_INIT, {16'h3332, 16'h0010});
        rd(mode_seq_pkg::ADDR_COUNTS, 32'h0000_1000);
        rd(8'h3c, 32'h0);
        wr(mode_seq_pkg::ADDR_INIT, {NET, 16'(INIT_N)});
        wr(mode_seq_pkg::ADDR_ADDR, {8'h00, NODE, NODE, CHAN});
        stall = 1'b1;
        host_send(64);
        repeat (80) tick();
        exp_packet(1'b1, 64);
        stall = 1'b0;
        wait_tx(13);
        host_send(5);
        exp_packet(1'b0, 5);
        wait_tx(INIT_N + 64 + 2 + 5 + 2);
        wait_mode(mode_seq_pkg::ST_IDLE, 20);
        RF_DETECT <= 1'b1;
        wait_mode(mode_seq_pkg::ST_RX, 10);
        host_send(2);
        exp_packet(1'b1, 2);
        rx_pkt(NODE, 1'b0);
        rx_pkt(8'ha5, 1'b0);
        chk("TX_VALID_RX", 0, {31'h0, TX_VALID});
        RF_DETECT <= 1'b0;
        wait_tx(beats + INIT_N + 4);
        wait_mode(mode_seq_pkg::ST_IDLE, 20);
        RF_DETECT <= 1'b1;
        wait_mode(mode_seq_pkg::ST_RX, 10);
        rx_pkt(NODE, 1'b1);
        RF_DETECT <= 1'b0;
        wait_mode(mode_seq_pkg::ST_IDLE, 10);
        rd(mode_seq_pkg::ADDR_CTRL, {16'h0002, 16'h0001});
        CMD_SEQ <= 1'b1;
        @(posedge CLOCK);
        CMD_SEQ <= 1'b0;
        wait_mode(mode_seq_pkg::ST_CMD, 10);
        wr(mode_seq_pkg::ADDR_CTRL, 32'h2);
        wait_mode(mode_seq_pkg::ST_IDLE, 10);
        sleep_req <= 1'b1;
        repeat (20) tick();
        chk("MODE_PIN_IGNORED", 0, {29'h0, MODE});
        wr(mode_seq_pkg::ADDR_SLEEP, 32'h1);
        wait_mode(mode_seq_pkg::ST_SLEEP, 20);
        repeat (2) tick();
        chk("PIN_SLEEP_PINS", 32'h2, {30'h0, CTS_B, PWR});
        sleep_req <= 1'b0;
        wait_mode(mode_seq_pkg::ST_IDLE, 20);
        tick();
        chk("PWR_AWAKE", 32'h1, {31'h0, PWR});
        wr(mode_seq_pkg::ADDR_COUNTS, 32'd20);
        wr(mode_seq_pkg::ADDR_SLEEP, 32'h3);
        wait_mode(mode_seq_pkg::ST_SLEEP, 60);
        for (n = 0; MODE === mode_seq_pkg::ST_SLEEP && n < 99; n++) tick();
        chk("SLEEP_LEN", 1, {31'h0, n >= 15 && n <= 18});
        for (n = 0; MODE === mode_seq_pkg::ST_IDLE && n < 99; n++) tick();
        chk("LISTEN_LEN", 1, {31'h0, n >= 49 && n <= 53});
        sleep_req <= 1'b1;
        wr(mode_seq_pkg::ADDR_SLEEP, 32'h13);
        sleep_req <= 1'b0;
        wait_mode(mode_seq_pkg::ST_IDLE, 6);
        wr(mode_seq_pkg::ADDR_SLEEP, 32'h0);
        wait_mode(mode_seq_pkg::ST_IDLE, 100);
        results();
    end
endmodule : radio_mode_sequencer_tb_top
